// ===== ghb_host_if.sv
module ghb_host_if (
  input wire logic CLK, // 100 MHz block clock
  input wire logic RST_N, // async reset, active low
  input wire logic BUS_STYLE_MCA, // strap: 1 = channel style
  input wire logic [19:0] HOST_ADDR, // host address
  input wire logic UPPER_BYTE_ENABLE_N, // upper byte enable, low
  input wire logic HOST_MEM_RD, // memory read request pulse
  input wire logic HOST_MEM_WR, // memory write request pulse
  input wire logic HOST_IO_RD, // i/o read request pulse
  input wire logic HOST_IO_WR, // i/o write request pulse
  input wire logic [15:0] HOST_WDATA, // host write data
  input wire logic FAST_SELECT, // fast handshake request
  input wire logic [7:0] DISPLAY_STATUS, // input status port value
  input wire logic [7:0] PAL_DATA_IN, // palette data bus in
  input wire logic MCLK_IN, // memory sequencing clock level
  input wire logic DOT_CLK_IN, // dot clock level
  input wire logic [31:0] MEM_RDATA, // plane read data
  output logic [15:0] HOST_RDATA, // host read data
  output logic HOST_READY, // transfer done pulse
  output logic HOST_WIDE16, // device takes 16-bit cycle
  output logic FAST_ACK, // fast handshake answer
  output logic VIDEO_ROM_SELECT_N, // video rom select, low
  output logic PAL_RD_N, // palette read strobe
  output logic PAL_WR_N, // palette write strobe
  output logic [1:0] PAL_ADDR, // palette register select
  output logic [7:0] PAL_DATA_OUT, // palette data bus out
  output logic PAL_DATA_OE, // palette data drive enable
  output logic [15:0] MEM_ADDR, // plane address
  output logic [3:0] MEM_PLANE_EN, // plane enables
  output logic MEM_CS_N, // memory strobe, low
  output logic MEM_WE_N, // memory write, low
  output logic [31:0] MEM_WDATA // plane write data
);
  logic strap_mca, strap_taken;
  logic [7:0] idx_reg [4];
  logic [7:0] misc_reg, ext_idx;
  logic attr_ff, unlock_a, unlock_b, mem16_en, io16_en, bank_hi;
  logic [3:0] map_mask;
  logic [1:0] read_map;
  logic chain4, odd_even;
  logic [7:0] latch [4];
  ghb_pkg::ghb_io_stage_t st1;
  logic hold_v;
  logic [15:0] hold_data;
  ghb_pkg::ghb_mem_req_t mreq;
  ghb_pkg::ghb_mstate_t mstate;
  logic second;
  logic [7:0] rd_lo, rd_hi;
  logic mclk_tick, dot_tick;
  logic [7:0] rf_rdata;
  // decode
  logic [15:0] pair_base, crt_idx, stat_port;
  logic hit_seq, hit_gfx, hit_crt, hit_attr, is_pair, ube, io_req, idle;
  logic word_io, io_hi, pal_hit, unlocked, win_hit, rom_hit, mem_req;
  logic [1:0] bank;
  logic [7:0] cur_idx, wbyte, dval, ext_rd, b_now, step_byte;
  logic rf_we;
  logic [ghb_pkg::RF_AW-1:0] rf_waddr, rf_raddr;
  logic [7:0] rf_wdata;
  logic [15:0] io_resp, mem_resp, step_addr;
  logic [1:0] step_pl, rd_pl;
  logic [3:0] wr_en;

  ghb_edge #(.RISE(1'b1)) u_mclk (
    .clk(CLK), .rst_n(RST_N), .lvl(MCLK_IN), .tick(mclk_tick)
  );
  // memory strobes launch on the falling dot edge
  ghb_edge #(.RISE(1'b0)) u_dot (
    .clk(CLK), .rst_n(RST_N), .lvl(DOT_CLK_IN), .tick(dot_tick)
  );
  ghb_regfile #(.AW(ghb_pkg::RF_AW), .DW(8)) u_rf (
    .clk(CLK), .rst_n(RST_N), .we(rf_we), .waddr(rf_waddr),
    .wdata(rf_wdata), .raddr(rf_raddr), .rdata(rf_rdata)
  );

  always_comb begin
    crt_idx = misc_reg[ghb_pkg::MISC_COLOR_BIT] ? ghb_pkg::CRT_COLOR_PORT
                                                : ghb_pkg::CRT_MONO_PORT;
    stat_port = misc_reg[ghb_pkg::MISC_COLOR_BIT] ? ghb_pkg::STAT_COLOR_PORT
                                                  : ghb_pkg::STAT_MONO_PORT;
    pair_base = {HOST_ADDR[15:1], 1'b0};
    hit_seq = pair_base == ghb_pkg::SEQ_IDX_PORT;
    hit_gfx = pair_base == ghb_pkg::GFX_IDX_PORT;
    hit_crt = pair_base == crt_idx;
    hit_attr = pair_base == ghb_pkg::ATTR_IDX_PORT;
    is_pair = hit_seq | hit_gfx | hit_crt | hit_attr;
    bank = hit_gfx ? ghb_pkg::BANK_GFX : hit_crt ? ghb_pkg::BANK_CRT :
           hit_attr ? ghb_pkg::BANK_ATTR : ghb_pkg::BANK_SEQ;
    cur_idx = idx_reg[bank];
    ube = ~UPPER_BYTE_ENABLE_N;
    io_req = HOST_IO_RD | HOST_IO_WR;
    idle = ~st1.valid & ~hold_v & (mstate == ghb_pkg::M_IDLE);
    word_io = io16_en & is_pair & ~HOST_ADDR[0] & ube;
    io_hi = io16_en & HOST_ADDR[0] & ube;
    wbyte = io_hi ? HOST_WDATA[15:8] : HOST_WDATA[7:0];
    pal_hit = (HOST_ADDR[15:0] >= ghb_pkg::PAL_FIRST_PORT) &&
              (HOST_ADDR[15:0] <= ghb_pkg::PAL_LAST_PORT);
    unlocked = unlock_a & unlock_b;
    win_hit = HOST_ADDR[19:17] == ghb_pkg::WIN_BASE_HI;
    rom_hit = HOST_ADDR[19:15] == ghb_pkg::ROM_BASE_HI;
    mem_req = (HOST_MEM_RD | HOST_MEM_WR) & win_hit & idle;
    // attribute data goes in on the second byte write to the index port
    rf_we = HOST_IO_WR & idle & (word_io | (is_pair & ~hit_attr &
            HOST_ADDR[0]) | (hit_attr & ~HOST_ADDR[0] & attr_ff));
    rf_waddr = {bank, word_io ? HOST_WDATA[4:0] : cur_idx[4:0]};
    rf_wdata = word_io ? HOST_WDATA[15:8] : wbyte;
    rf_raddr = {bank, cur_idx[4:0]};
    ext_rd = ghb_pkg::RESET_BYTE;
    if (ext_idx == ghb_pkg::EXT_UNLOCK_A) ext_rd = {7'h00, unlock_a};
    else if (ext_idx == ghb_pkg::EXT_UNLOCK_B) ext_rd = {7'h00, unlock_b};
    else if (!unlocked) ext_rd = ghb_pkg::RESET_BYTE;
    else if (ext_idx == ghb_pkg::EXT_WIDTH) ext_rd = {6'h00, io16_en, mem16_en};
    else if (ext_idx[7:2] == ghb_pkg::EXT_LATCH_BASE[7:2])
      ext_rd = latch[ext_idx[1:0]];
    else if (ext_idx == ghb_pkg::EXT_ATTR_FF) ext_rd = {7'h00, attr_ff};
    else if (ext_idx == ghb_pkg::EXT_BANK) ext_rd = {7'h00, bank_hi};
    if (is_pair) dval = cur_idx;
    else if (HOST_ADDR[15:0] == ghb_pkg::MISC_RD_PORT) dval = misc_reg;
    else if (HOST_ADDR[15:0] == stat_port) dval = DISPLAY_STATUS;
    else if (HOST_ADDR[15:0] == ghb_pkg::EXT_IDX_PORT) dval = ext_idx;
    else if (HOST_ADDR[15:0] == ghb_pkg::EXT_DAT_PORT) dval = ext_rd;
    else dval = ghb_pkg::RESET_BYTE;
    b_now = st1.from_rf ? rf_rdata : st1.from_pal ? PAL_DATA_IN : st1.dval;
    io_resp = st1.word ? {rf_rdata, st1.dval} :
              st1.hi ? {b_now, 8'h00} : {8'h00, b_now};
    mem_resp = mreq.two ? {rd_hi, rd_lo} :
               mreq.hi ? {rd_hi, 8'h00} : {8'h00, rd_hi};
    // chain4 and odd/even map the 18-bit linear offset onto planes; planar uses offset bits 15:0 and takes the plane from read_map
    if (chain4) begin
      step_addr = mreq.lin[17:2];
      step_pl = mreq.lin[1:0];
    end else if (odd_even) begin
      step_addr = mreq.lin[16:1];
      step_pl = {mreq.lin[17], mreq.lin[0]};
    end else begin
      step_addr = mreq.lin[15:0];
      step_pl = read_map;
    end
    rd_pl = step_pl;
    wr_en = (chain4 | odd_even) ? (4'h1 << step_pl) & map_mask : map_mask;
    step_byte = (second | mreq.hi) ? mreq.wdata[15:8] : mreq.wdata[7:0];
  end

  // strap is caught once after reset release
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_mca <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap_mca <= BUS_STYLE_MCA;
      strap_taken <= 1'b1;
    end
  end

  // standard indexes, misc, attribute toggle and register shadows
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 4; i++) idx_reg[i] <= ghb_pkg::RESET_BYTE;
      misc_reg <= ghb_pkg::RESET_BYTE;
      attr_ff <= 1'b0;
      map_mask <= 4'h0;
      read_map <= 2'h0;
      chain4 <= 1'b0;
      odd_even <= 1'b0;
    end else if (io_req && idle) begin
      if (HOST_IO_WR && is_pair && !HOST_ADDR[0] &&
          (!hit_attr || word_io || !attr_ff))
        idx_reg[bank] <= HOST_WDATA[7:0];
      if (HOST_IO_WR && hit_attr && !HOST_ADDR[0] && !word_io)
        attr_ff <= ~attr_ff;
      if (HOST_IO_RD && HOST_ADDR[15:0] == stat_port)
        attr_ff <= 1'b0;
      if (HOST_IO_WR && HOST_ADDR[15:0] == ghb_pkg::MISC_WR_PORT)
        misc_reg <= wbyte;
      // shadows follow the standard bit layout, nothing added
      if (rf_we && rf_waddr == {ghb_pkg::BANK_SEQ, ghb_pkg::SEQ_MAP_MASK})
        map_mask <= rf_wdata[3:0];
      if (rf_we && rf_waddr == {ghb_pkg::BANK_SEQ, ghb_pkg::SEQ_MEM_MODE})
        chain4 <= rf_wdata[ghb_pkg::CHAIN4_BIT];
      if (rf_we && rf_waddr == {ghb_pkg::BANK_GFX, ghb_pkg::GFX_READ_MAP})
        read_map <= rf_wdata[1:0];
      if (rf_we && rf_waddr == {ghb_pkg::BANK_GFX, ghb_pkg::GFX_MODE})
        odd_even <= rf_wdata[ghb_pkg::ODD_EVEN_BIT];
    end
  end

  // extended registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_idx <= ghb_pkg::RESET_BYTE;
      unlock_a <= 1'b0;
      unlock_b <= 1'b0;
      mem16_en <= 1'b0;
      io16_en <= 1'b0;
      bank_hi <= 1'b0;
    end else if (HOST_IO_WR && idle) begin
      if (HOST_ADDR[15:0] == ghb_pkg::EXT_IDX_PORT) ext_idx <= wbyte;
      if (HOST_ADDR[15:0] == ghb_pkg::EXT_DAT_PORT) begin
        if (ext_idx == ghb_pkg::EXT_UNLOCK_A) unlock_a <= wbyte[0];
        if (ext_idx == ghb_pkg::EXT_UNLOCK_B) unlock_b <= wbyte[0];
        if (unlocked && ext_idx == ghb_pkg::EXT_WIDTH) begin
          mem16_en <= wbyte[ghb_pkg::WIDTH_MEM_BIT];
          io16_en <= wbyte[ghb_pkg::WIDTH_IO_BIT];
        end
        if (unlocked && ext_idx == ghb_pkg::EXT_BANK) bank_hi <= wbyte[0];
      end
    end
  end

  // i/o pipeline, host answer, palette and rom strobes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st1 <= '0;
      hold_v <= 1'b0;
      hold_data <= 16'h0000;
      HOST_RDATA <= 16'h0000;
      HOST_READY <= 1'b0;
      HOST_WIDE16 <= 1'b0;
      FAST_ACK <= 1'b0;
      VIDEO_ROM_SELECT_N <= 1'b1;
      PAL_RD_N <= 1'b1;
      PAL_WR_N <= 1'b1;
      PAL_ADDR <= 2'h0;
      PAL_DATA_OUT <= ghb_pkg::RESET_BYTE;
      PAL_DATA_OE <= 1'b0;
    end else begin
      st1.valid <= io_req & idle;
      st1.word <= word_io;
      st1.hi <= io_hi;
      st1.from_rf <= is_pair & HOST_ADDR[0];
      st1.from_pal <= pal_hit;
      st1.fast <= FAST_SELECT;
      st1.dval <= dval;
      HOST_WIDE16 <= (io_req & idle & word_io) |
                     (mem_req & mem16_en & ~HOST_ADDR[0] & ube);
      VIDEO_ROM_SELECT_N <= ~(HOST_MEM_RD & rom_hit & idle & ~strap_mca);
      PAL_RD_N <= ~(HOST_IO_RD & idle & pal_hit);
      PAL_WR_N <= ~(HOST_IO_WR & idle & pal_hit);
      PAL_DATA_OE <= HOST_IO_WR & idle & pal_hit;
      if (io_req && idle && pal_hit) begin
        PAL_ADDR <= HOST_ADDR[1:0] ^ 2'h2;
        PAL_DATA_OUT <= wbyte;
      end
      hold_v <= st1.valid & ~st1.fast;
      hold_data <= io_resp;
      HOST_READY <= 1'b0;
      FAST_ACK <= 1'b0;
      // fixed latency on i/o: answer 2 cycles after the request with FAST_SELECT, 3 cycles without
      if (st1.valid && st1.fast) begin
        HOST_READY <= 1'b1;
        FAST_ACK <= 1'b1;
        HOST_RDATA <= io_resp;
      end else if (hold_v) begin
        HOST_READY <= 1'b1;
        HOST_RDATA <= hold_data;
      end else if (mstate == ghb_pkg::M_DONE) begin
        HOST_READY <= 1'b1;
        HOST_RDATA <= mem_resp;
      end
    end
  end

  // display memory sequencer: steps on mclk, strobe on dot clock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mstate <= ghb_pkg::M_IDLE;
      mreq <= '0;
      second <= 1'b0;
      rd_lo <= ghb_pkg::RESET_BYTE;
      rd_hi <= ghb_pkg::RESET_BYTE;
      for (int i = 0; i < 4; i++) latch[i] <= ghb_pkg::RESET_BYTE;
      MEM_ADDR <= 16'h0000;
      MEM_PLANE_EN <= 4'h0;
      MEM_CS_N <= 1'b1;
      MEM_WE_N <= 1'b1;
      MEM_WDATA <= 32'h0000_0000;
    end else begin
      unique case (mstate)
        ghb_pkg::M_IDLE: if (mem_req) begin
          mreq.lin <= {bank_hi, HOST_ADDR[16:0]};
          mreq.wr <= HOST_MEM_WR;
          mreq.two <= mem16_en & ~HOST_ADDR[0] & ube;
          mreq.hi <= mem16_en & HOST_ADDR[0] & ube;
          mreq.wdata <= HOST_WDATA;
          second <= 1'b0;
          mstate <= ghb_pkg::M_ADDR;
        end
        ghb_pkg::M_ADDR: if (mclk_tick) begin
          MEM_ADDR <= step_addr;
          MEM_PLANE_EN <= mreq.wr ? wr_en : 4'hf;
          MEM_WDATA <= {4{step_byte}};
          mstate <= ghb_pkg::M_STROBE;
        end
        ghb_pkg::M_STROBE: if (dot_tick) begin
          MEM_CS_N <= 1'b0;
          MEM_WE_N <= ~mreq.wr;
          mstate <= ghb_pkg::M_CAPT;
        end
        ghb_pkg::M_CAPT: if (mclk_tick) begin
          MEM_CS_N <= 1'b1;
          MEM_WE_N <= 1'b1;
          if (!mreq.wr) begin
            for (int i = 0; i < 4; i++) latch[i] <= MEM_RDATA[8*i +: 8];
          end
          // a word is two byte steps, the upper one at the next offset
          if (mreq.two && !second) begin
            rd_lo <= MEM_RDATA[8*rd_pl +: 8];
            second <= 1'b1;
            mreq.lin <= mreq.lin + 18'h00001;
            mstate <= ghb_pkg::M_ADDR;
          end else begin
            rd_hi <= MEM_RDATA[8*rd_pl +: 8];
            mstate <= ghb_pkg::M_DONE;
          end
        end
        ghb_pkg::M_DONE: mstate <= ghb_pkg::M_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_io_fast;
    io_req && idle && FAST_SELECT |-> ##2 HOST_READY && FAST_ACK;
  endproperty
  a_io_fast: assert property (p_io_fast) else $error("fast io late");

  property p_io_slow;
    io_req && idle && !FAST_SELECT |-> ##2 !HOST_READY ##1 HOST_READY;
  endproperty
  a_io_slow: assert property (p_io_slow) else $error("io not 3 cycles");

  property p_mem_hold;
    mstate != ghb_pkg::M_IDLE |-> !HOST_READY;
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("early ready");

  property p_mem_release;
    mstate == ghb_pkg::M_DONE |=> HOST_READY ##1 !HOST_READY;
  endproperty
  a_mem_release: assert property (p_mem_release) else $error("ready");

  property p_ext_lock;
    HOST_IO_WR && idle && !unlocked && ext_idx == ghb_pkg::EXT_WIDTH &&
      HOST_ADDR[15:0] == ghb_pkg::EXT_DAT_PORT |=> $stable(io16_en) &&
      $stable(mem16_en);
  endproperty
  a_ext_lock: assert property (p_ext_lock) else $error("lock broken");

  property p_byte_port;
    io_req && idle && !is_pair |=> !HOST_WIDE16;
  endproperty
  a_byte_port: assert property (p_byte_port) else $error("wide port");

  property p_word_io;
    io_req && idle && io16_en && is_pair && !HOST_ADDR[0] && ube
      |=> HOST_WIDE16;
  endproperty
  a_word_io: assert property (p_word_io) else $error("no word io");

  property p_rom;
    HOST_MEM_RD && rom_hit && idle |=> VIDEO_ROM_SELECT_N == strap_mca;
  endproperty
  a_rom: assert property (p_rom) else $error("rom select wrong");

  property p_pal;
    HOST_IO_WR && idle && pal_hit |=> !PAL_WR_N && PAL_DATA_OE ##1 PAL_WR_N;
  endproperty
  a_pal: assert property (p_pal) else $error("palette strobe");

  property p_strobe_dot;
    $fell(MEM_CS_N) |-> $past(dot_tick);
  endproperty
  a_strobe_dot: assert property (p_strobe_dot) else $error("no dot");

  property p_attr_ff;
    HOST_IO_WR && idle && hit_attr && !HOST_ADDR[0] && !word_io
      |=> attr_ff != $past(attr_ff);
  endproperty
  a_attr_ff: assert property (p_attr_ff) else $error("toggle stuck");
endmodule

// ===== ghb_pkg.sv
package ghb_pkg;
  // host i/o map
  localparam logic [15:0] ATTR_IDX_PORT = 16'h03c0;
  localparam logic [15:0] MISC_WR_PORT = 16'h03c2;
  localparam logic [15:0] SEQ_IDX_PORT = 16'h03c4;
  localparam logic [15:0] PAL_FIRST_PORT = 16'h03c6;
  localparam logic [15:0] PAL_LAST_PORT = 16'h03c9;
  localparam logic [15:0] MISC_RD_PORT = 16'h03cc;
  localparam logic [15:0] GFX_IDX_PORT = 16'h03ce;
  localparam logic [15:0] CRT_MONO_PORT = 16'h03b4;
  localparam logic [15:0] CRT_COLOR_PORT = 16'h03d4;
  localparam logic [15:0] STAT_MONO_PORT = 16'h03ba;
  localparam logic [15:0] STAT_COLOR_PORT = 16'h03da;
  localparam logic [15:0] EXT_IDX_PORT = 16'h03d6;
  localparam logic [15:0] EXT_DAT_PORT = 16'h03d7;
  // indexed register banks
  localparam logic [1:0] BANK_SEQ = 2'h0;
  localparam logic [1:0] BANK_GFX = 2'h1;
  localparam logic [1:0] BANK_CRT = 2'h2;
  localparam logic [1:0] BANK_ATTR = 2'h3;
  localparam int IDX_W = 5;
  localparam int RF_AW = 7;
  localparam logic [4:0] SEQ_MAP_MASK = 5'h02;
  localparam logic [4:0] SEQ_MEM_MODE = 5'h04;
  localparam int CHAIN4_BIT = 3;
  localparam logic [4:0] GFX_READ_MAP = 5'h04;
  localparam logic [4:0] GFX_MODE = 5'h05;
  localparam int ODD_EVEN_BIT = 4;
  localparam int MISC_COLOR_BIT = 0;
  // extended registers
  localparam logic [7:0] EXT_UNLOCK_A = 8'h00;
  localparam logic [7:0] EXT_UNLOCK_B = 8'h01;
  localparam logic [7:0] EXT_WIDTH = 8'h02;
  localparam logic [7:0] EXT_LATCH_BASE = 8'h04;
  localparam logic [7:0] EXT_ATTR_FF = 8'h08;
  localparam logic [7:0] EXT_BANK = 8'h09;
  localparam int WIDTH_MEM_BIT = 0;
  localparam int WIDTH_IO_BIT = 1;
  // memory decode: a0000-bffff window, c0000-c7fff video rom
  localparam logic [2:0] WIN_BASE_HI = 3'h5;
  localparam logic [4:0] ROM_BASE_HI = 5'h18;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [2:0] {
    M_IDLE, M_ADDR, M_STROBE, M_CAPT, M_DONE
  } ghb_mstate_t;

  typedef struct packed {
    logic [17:0] lin;
    logic wr;
    logic two;
    logic hi;
    logic [15:0] wdata;
  } ghb_mem_req_t;

  typedef struct packed {
    logic valid;
    logic word;
    logic hi;
    logic from_rf;
    logic from_pal;
    logic fast;
    logic [7:0] dval;
  } ghb_io_stage_t;
endpackage

// ===== ghb_edge.sv
module ghb_edge #(
  parameter bit RISE = 1'b1
) (
  input wire logic clk, // block clock
  input wire logic rst_n, // async reset, active low
  input wire logic lvl, // sampled clock level
  output logic tick // one-cycle pulse per chosen edge
);
  logic prev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
      tick <= 1'b0;
    end else begin
      prev <= lvl;
      tick <= RISE ? (lvl & ~prev) : (~lvl & prev);
    end
  end
endmodule

// ===== ghb_regfile.sv
module ghb_regfile #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk, // block clock
  input wire logic rst_n, // async reset, active low
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write address
  input wire logic [DW-1:0] wdata, // write data
  input wire logic [AW-1:0] raddr, // read address
  output logic [DW-1:0] rdata // registered read data
);
  logic [DW-1:0] mem [2**AW];

  // array has no reset: contents of standard registers are undefined at power-up
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ===== ghb_mem_model.sv
module ghb_mem_model (
  input wire logic CLK, // block clock
  input wire logic [15:0] MEM_ADDR, // plane address
  input wire logic [3:0] MEM_PLANE_EN, // plane enables
  input wire logic MEM_CS_N, // memory strobe, low
  input wire logic MEM_WE_N, // memory write, low
  input wire logic [31:0] MEM_WDATA, // plane write data
  output logic [31:0] MEM_RDATA, // plane read data
  input wire logic PAL_RD_N, // palette read strobe
  output logic [7:0] PAL_DATA_IN, // palette data bus
  output logic MCLK_IN, // memory sequencing clock
  output logic DOT_CLK_IN // dot clock
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] PAL_VAL = 8'ha7;
  logic [31:0] mem [256];
  // clocks unrelated to the block clock, so sequencer waits vary
  initial begin
    MCLK_IN = 1'b0;
    forever #20 MCLK_IN = ~MCLK_IN;
  end
  initial begin
    DOT_CLK_IN = 1'b0;
    // offset keeps dot edges clear of the block clock edge
    #2;
    forever #15 DOT_CLK_IN = ~DOT_CLK_IN;
  end
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
  end
  always @(posedge CLK) begin
    for (int i = 0; i < 4; i++)
      if (!MEM_CS_N && !MEM_WE_N && MEM_PLANE_EN[i])
        mem[MEM_ADDR[7:0]][8*i+:8] <= MEM_WDATA[8*i+:8];
  end
  assign MEM_RDATA = mem[MEM_ADDR[7:0]];
  // undriven palette bus shows the inverse, not a stale value
  assign PAL_DATA_IN = PAL_RD_N ? ~PAL_VAL : PAL_VAL;
endmodule

// ===== graphics_host_bus_interface_test.sv
module graphics_host_bus_interface_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK, RST_N, BUS_STYLE_MCA, UPPER_BYTE_ENABLE_N, FAST_SELECT;
  logic HOST_MEM_RD, HOST_MEM_WR, HOST_IO_RD, HOST_IO_WR;
  logic [19:0] HOST_ADDR;
  logic [15:0] HOST_WDATA, HOST_RDATA, MEM_ADDR;
  logic [7:0] PAL_DATA_IN, PAL_DATA_OUT;
  logic MCLK_IN, DOT_CLK_IN, HOST_READY, HOST_WIDE16, FAST_ACK, PAL_DATA_OE;
  logic VIDEO_ROM_SELECT_N, PAL_RD_N, PAL_WR_N, MEM_CS_N, MEM_WE_N;
  logic [1:0] PAL_ADDR;
  logic [3:0] MEM_PLANE_EN;
  logic [31:0] MEM_RDATA, MEM_WDATA;
  logic wide, rom_n, fack, csl;
  logic [9:0] pw;
  logic [15:0] rdat;
  int lat, checks = 0, miscompares = 0;

  ghb_host_if u_ghb_host_if (.CLK(CLK), .RST_N(RST_N),
    .BUS_STYLE_MCA(BUS_STYLE_MCA), .HOST_ADDR(HOST_ADDR),
    .UPPER_BYTE_ENABLE_N(UPPER_BYTE_ENABLE_N), .HOST_MEM_RD(HOST_MEM_RD),
    .HOST_MEM_WR(HOST_MEM_WR), .HOST_IO_RD(HOST_IO_RD),
    .HOST_IO_WR(HOST_IO_WR), .HOST_WDATA(HOST_WDATA),
    .FAST_SELECT(FAST_SELECT), .DISPLAY_STATUS(8'h96),
    .PAL_DATA_IN(PAL_DATA_IN), .MCLK_IN(MCLK_IN), .DOT_CLK_IN(DOT_CLK_IN),
    .MEM_RDATA(MEM_RDATA), .HOST_RDATA(HOST_RDATA), .HOST_READY(HOST_READY),
    .HOST_WIDE16(HOST_WIDE16), .FAST_ACK(FAST_ACK),
    .VIDEO_ROM_SELECT_N(VIDEO_ROM_SELECT_N), .PAL_RD_N(PAL_RD_N),
    .PAL_WR_N(PAL_WR_N), .PAL_ADDR(PAL_ADDR), .PAL_DATA_OUT(PAL_DATA_OUT),
    .PAL_DATA_OE(PAL_DATA_OE), .MEM_ADDR(MEM_ADDR),
    .MEM_PLANE_EN(MEM_PLANE_EN), .MEM_CS_N(MEM_CS_N), .MEM_WE_N(MEM_WE_N),
    .MEM_WDATA(MEM_WDATA));
  ghb_mem_model u_ghb_mem_model (.CLK(CLK), .MEM_ADDR(MEM_ADDR),
    .MEM_PLANE_EN(MEM_PLANE_EN), .MEM_CS_N(MEM_CS_N), .MEM_WE_N(MEM_WE_N),
    .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .PAL_RD_N(PAL_RD_N),
    .PAL_DATA_IN(PAL_DATA_IN), .MCLK_IN(MCLK_IN), .DOT_CLK_IN(DOT_CLK_IN));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic snap();
    csl = csl | ~MEM_CS_N;
    if (!PAL_WR_N) pw = {PAL_ADDR, PAL_DATA_OUT};
    if (!PAL_RD_N) pw = {PAL_ADDR, 8'h00};
  endtask

  // one transfer; waits a bounded time for the answer
  task automatic req(input bit mem, input bit wr, input logic [19:0] a,
      input logic ube_n, input logic [15:0] d, input logic f);
    @(posedge CLK);
    #1;
    {HOST_ADDR, UPPER_BYTE_ENABLE_N, HOST_WDATA, FAST_SELECT} = {a,ube_n,d,f};
    {HOST_MEM_RD, HOST_MEM_WR, HOST_IO_RD, HOST_IO_WR} = 4'h1 << {mem, ~wr};
    @(posedge CLK);
    #1;
    {HOST_MEM_RD, HOST_MEM_WR, HOST_IO_RD, HOST_IO_WR} = 4'h0;
    {wide, rom_n, csl, pw} = {HOST_WIDE16, VIDEO_ROM_SELECT_N, 1'b0, 10'h0};
    snap();
    lat = 0;
    while (lat < 200 && HOST_READY !== 1'b1) begin
      @(posedge CLK);
      #1;
      lat++;
      snap();
    end
    {fack, rdat} = {FAST_ACK, HOST_RDATA};
  endtask

  task automatic wr8(input logic [19:0] a, input logic [7:0] d);
    req(0, 1, a, 1'b1, {8'h00, d}, 1'b0);
  endtask

  task automatic do_reset(input logic mca);
    RST_N = 1'b0;
    BUS_STYLE_MCA = mca;
    repeat (4) @(posedge CLK);
    #1 RST_N = 1'b1;
    cmp({VIDEO_ROM_SELECT_N, PAL_RD_N, PAL_WR_N, MEM_CS_N, HOST_READY}, 5'h1e);
    repeat (2) @(posedge CLK);
  endtask

  task automatic s_io_byte();
    req(0, 1, 20'h003c4, 1'b0, 16'h0f02, 1'b0);
    cmp(wide, 1'b0);
    wr8(20'h003c5, 8'h0f);
    req(0, 0, 20'h003c5, 1'b1, 16'h0, 1'b0);
    cmp(lat, 2);
    cmp(rdat, 16'h000f);
    req(0, 0, 20'h003c5, 1'b1, 16'h0, 1'b1);
    cmp({fack, 8'(lat)}, 9'h101);
  endtask

  task automatic s_unlock();
    wr8(20'h003d6, 8'h02);
    wr8(20'h003d7, 8'h03);
    req(0, 0, 20'h003d7, 1'b1, 16'h0, 1'b0);
    cmp(rdat, 16'h0000);
    wr8(20'h003d6, 8'h00);
    wr8(20'h003d7, 8'h01);
  endtask

  task automatic s_wide_io();
    wr8(20'h003d6, 8'h01);
    wr8(20'h003d7, 8'h01);
    wr8(20'h003d6, 8'h02);
    wr8(20'h003d7, 8'h03);
    req(0, 0, 20'h003d7, 1'b1, 16'h0, 1'b0);
    cmp(rdat, 16'h0003);
    req(0, 1, 20'h003c4, 1'b0, 16'h0f02, 1'b0);
    cmp(wide, 1'b1);
    req(0, 0, 20'h003c4, 1'b0, 16'h0, 1'b0);
    cmp({wide, rdat}, 17'h10f02);
    req(0, 0, 20'h003c5, 1'b0, 16'h0, 1'b0);
    cmp({wide, rdat}, 17'h00f00);
    req(0, 0, 20'h003c4, 1'b1, 16'h0, 1'b0);
    cmp({wide, rdat}, 17'h00002);
    req(0, 0, 20'h003cc, 1'b0, 16'h0, 1'b0);
    cmp(wide, 1'b0);
  endtask

  task automatic s_pal();
    wr8(20'h003c8, 8'h5a);
    cmp(pw, {2'h2, 8'h5a});
    req(0, 0, 20'h003c7, 1'b1, 16'h0, 1'b0);
    cmp({pw, rdat}, {2'h1, 8'h00, 16'h00a7});
  endtask

  task automatic s_mem();
    wr8(20'h003c4, 8'h04);
    wr8(20'h003c5, 8'h00);
    wr8(20'h003ce, 8'h04);
    wr8(20'h003cf, 8'h00);
    wr8(20'h003ce, 8'h05);
    wr8(20'h003cf, 8'h00);
    req(1, 1, 20'ha0000, 1'b0, 16'hc33c, 1'b0);
    cmp({wide, csl, 1'(lat > 3)}, 3'h7);
    req(1, 0, 20'ha0000, 1'b0, 16'h0, 1'b0);
    cmp(rdat, 16'hc33c);
    wr8(20'h003c4, 8'h04);
    wr8(20'h003c5, 8'h08);
    req(1, 1, 20'ha0003, 1'b1, 16'h0077, 1'b0);
    req(1, 0, 20'ha0003, 1'b1, 16'h0, 1'b0);
    cmp(rdat, 16'h0077);
    // odd/even: offset 5 is plane 1, address 2
    wr8(20'h003c5, 8'h00);
    wr8(20'h003ce, 8'h05);
    wr8(20'h003cf, 8'h10);
    req(1, 1, 20'ha0005, 1'b1, 16'h0055, 1'b0);
    req(1, 0, 20'ha0005, 1'b1, 16'h0, 1'b0);
    cmp(rdat, 16'h0055);
  endtask

  task automatic s_attr();
    wr8(20'h003c0, 8'h10);
    wr8(20'h003d6, 8'h08);
    req(0, 0, 20'h003d7, 1'b1, 16'h0, 1'b0);
    cmp(rdat, 16'h0001);
    req(0, 0, 20'h003ba, 1'b1, 16'h0, 1'b0);
    cmp(rdat, 16'h0096);
    req(0, 0, 20'h003d7, 1'b1, 16'h0, 1'b0);
    cmp(rdat, 16'h0000);
    wr8(20'h003d6, 8'h05);
    req(0, 0, 20'h003d7, 1'b1, 16'h0, 1'b0);
    cmp(rdat, 16'h0055);
  endtask

  task automatic s_rom(input logic mca);
    req(1, 0, 20'hc0000, 1'b1, 16'h0, 1'b0);
    cmp({rom_n, 8'(lat)}, {mca, 8'd200});
  endtask

  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100us;
    miscompares++;
    wrap_up();
  end

  initial begin
    {HOST_MEM_RD, HOST_MEM_WR, HOST_IO_RD, HOST_IO_WR} = 4'h0;
    {HOST_ADDR, UPPER_BYTE_ENABLE_N, HOST_WDATA, FAST_SELECT} = '0;
    do_reset(1'b0);
    s_io_byte();
    s_unlock();
    s_wide_io();
    s_pal();
    s_mem();
    s_attr();
    s_rom(1'b0);
    do_reset(1'b1);
    req(0, 0, 20'h003c4, 1'b0, 16'h0, 1'b0);
    cmp(wide, 1'b0);
    req(0, 0, 20'h003d7, 1'b1, 16'h0, 1'b0);
    cmp(rdat, 16'h0000);
    s_rom(1'b1);
    wrap_up();
  end
endmodule
